// ==== src/afe_map.svh ====
`ifndef AFE_MAP_SVH
`define AFE_MAP_SVH

// ****************************************
// Register addresses
// ****************************************
`define AFE_ADDR_SETUP1   6'h01
`define AFE_ADDR_SETUP2   6'h02
`define AFE_ADDR_SETUP3   6'h03
`define AFE_ADDR_SOFTRST  6'h04
`define AFE_ADDR_CYCRST   6'h05

// ****************************************
// Reset values and writable masks
// ****************************************
`define AFE_RST_SETUP1    8'h03
`define AFE_RST_SETUP2    8'h20
`define AFE_RST_SETUP3    8'h1F
`define AFE_MASK_SETUP1   8'h7F
`define AFE_MASK_SETUP2   8'hEF
`define AFE_MASK_SETUP3   8'hFF

// ****************************************
// Field positions
// ****************************************
`define AFE_S1_EN         0
`define AFE_S1_CDS        1
`define AFE_S1_MONO       2
`define AFE_S1_SELECTIVE_POWERDOWN_ENABLE      3
`define AFE_S1_OFS_LO     4
`define AFE_S1_MAXSPD     6
`define AFE_S2_FMT_LO     0
`define AFE_S2_INV        2
`define AFE_S2_DACEXT     3
`define AFE_S2_SPAN       5
`define AFE_S2_DEL_LO     6
`define AFE_S3_CLAMP_LO   0
`define AFE_S3_SHIFT_LO   4
`define AFE_S3_CHAN_LO    6

// ****************************************
// Timing counts in master clocks
// ****************************************
`define AFE_ADC_MCLK_NORM 4'h2
`define AFE_ADC_MCLK_FAST 4'h3
`define AFE_MAX_LAT_MCLK  9
`endif

// ==== src/afe_pkg.sv ====
// ****************************************
// Shared types of the setup register bank
// ****************************************
package afe_pkg;
    // One register byte
    typedef logic [7:0] afe_byte_t;

    // Whole state of the register bank
    typedef struct packed {
        afe_byte_t   setup1;
        afe_byte_t   setup2;
        afe_byte_t   setup3;
        afe_byte_t   rdata;
        logic        chip_active;
        logic [3:0]  block_en;
        logic        cds;
        logic        mono;
        logic [1:0]  chan;
        logic [1:0]  ofs;
        logic        max_speed;
        logic [1:0]  bus_fmt;
        logic        invert;
        logic        dac_oe;
        logic        dac_span;
        logic [1:0]  lat_sel;
        logic [3:0]  lat_mclk;
        logic [3:0]  clamp_code;
        logic [1:0]  sample_shift;
        logic        soft_rst;
        logic        cyc_rst;
    } afe_regs_s;
endpackage

// ==== src/afe_cfg_if.sv ====
// ****************************************
// Settings passed to the output data path
// ****************************************
interface afe_cfg_if;
    logic       invert;     // Invert every output word
    logic [3:0] lat_mclk;   // Extra delay in master clocks
    logic       flush;      // Soft reset of the path
    modport cfg (output invert, output lat_mclk, output flush);
    modport dp  (input invert, input lat_mclk, input flush);
endinterface

// ==== src/afe_out_path.sv ====
// ****************************************
// Output data path: latency and inversion
// ****************************************
module afe_out_path #(
    parameter int W     = 14,
    parameter int DEPTH = 9
) (
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    afe_cfg_if.dp              cfg,
    input  wire logic [W-1:0]  data_in,
    output logic [W-1:0]       data_out
);
    // All state of the path
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] pipe;
        logic [W-1:0]            out;
    } afe_path_s;

    afe_path_s s_q;
    afe_path_s s_d;
    logic [W-1:0] pick;   // Word chosen by the latency setting

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        s_d = s_q;
        s_d.pipe[0] = data_in;
        for (int k = 1; k < DEPTH; k++)
        begin
            s_d.pipe[k] = s_q.pipe[k-1];
        end
        if (cfg.lat_mclk == 4'h0)
        begin
            pick = data_in;
        end
        else
        begin
            pick = s_q.pipe[cfg.lat_mclk - 4'h1];
        end
        s_d.out = cfg.invert ? ~pick : pick;
        // A soft reset clears every stage too
        if (cfg.flush)
        begin
            s_d = '0;
        end
    end

    // State register
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign data_out = s_q.out;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_min_latency;
        (cfg.lat_mclk == 4'h0 && !cfg.flush)
            |=> data_out == ($past(cfg.invert) ? ~$past(data_in) : $past(data_in));
    endproperty
    a_min_latency: assert property (p_min_latency)
        else $error("output word not matching inverted input");
endmodule

// ==== src/afe_regs.sv ====
`include "afe_map.svh"

// ****************************************
// Setup register bank of the front end
// ****************************************
module afe_regs #(
    parameter int DATA_W = 14
) (
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              host_wr_en,
    input  wire logic              host_rd_en,
    input  wire logic [5:0]        host_addr,
    input  wire logic [7:0]        host_wdata,
    input  wire logic              line_sequential_enable,
    input  wire logic              fast_line_mode,
    input  wire logic [3:0]        block_disable_field,
    input  wire logic [DATA_W-1:0] adc_word,
    output logic [7:0]             host_rdata,
    output logic                   chip_active,
    output logic [3:0]             block_enable,
    output logic                   cds_enable,
    output logic                   mono_active,
    output logic [1:0]             mono_channel,
    output logic [1:0]             gain_stage_offset_polarity,
    output logic                   max_speed_mode_flag,
    output logic [1:0]             output_bus_format,
    output logic                   output_invert,
    output logic                   clamp_reference_dac_oe,
    output logic                   clamp_dac_span,
    output logic [1:0]             output_latency_select,
    output logic [3:0]             latency_mclk,
    output logic [3:0]             clamp_level_code,
    output logic [1:0]             reset_sample_shift,
    output logic                   soft_reset_pulse,
    output logic                   colour_cycle_reset,
    output logic [DATA_W-1:0]      data_out
);

    // ****************************************
    // Helpers
    // ****************************************

    // True for a write at one address
    function automatic logic wr_at(input logic en, input logic [5:0] a,
                                   input logic [5:0] target);
        return en && (a == target);
    endfunction

    // Master clocks for a count of converter periods
    function automatic logic [3:0] to_mclk(input logic [1:0] del,
                                          input logic fast);
        logic [3:0] per;
        per = fast ? `AFE_ADC_MCLK_FAST : `AFE_ADC_MCLK_NORM;
        return 4'(per * {2'b00, del});
    endfunction

    // Default state after any reset
    localparam afe_pkg::afe_regs_s RST_STATE = '{
        setup1:       `AFE_RST_SETUP1,
        setup2:       `AFE_RST_SETUP2,
        setup3:       `AFE_RST_SETUP3,
        rdata:        8'h00,
        chip_active:  1'b1,
        block_en:     4'hF,
        cds:          1'b1,
        mono:         1'b0,
        chan:         2'b00,
        ofs:          2'b00,
        max_speed:    1'b0,
        bus_fmt:      2'b00,
        invert:       1'b0,
        dac_oe:       1'b1,
        dac_span:     1'b1,
        lat_sel:      2'b00,
        lat_mclk:     4'h0,
        clamp_code:   4'hF,
        sample_shift: 2'b01,
        soft_rst:     1'b0,
        cyc_rst:      1'b0
    };

    // ****************************************
    // State
    // ****************************************
    afe_pkg::afe_regs_s s_q;   // Registered state
    afe_pkg::afe_regs_s s_d;   // Next state
    afe_cfg_if          cfg_bus ();

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        s_d = s_q;
        s_d.soft_rst = 1'b0;
        s_d.cyc_rst  = 1'b0;

        if (wr_at(host_wr_en, host_addr, `AFE_ADDR_SETUP1))
        begin
            // Unused top bit is kept at zero
            s_d.setup1 = host_wdata & `AFE_MASK_SETUP1;
        end
        if (wr_at(host_wr_en, host_addr, `AFE_ADDR_SETUP2))
        begin
            s_d.setup2 = host_wdata & `AFE_MASK_SETUP2;
        end
        if (wr_at(host_wr_en, host_addr, `AFE_ADDR_SETUP3))
        begin
            s_d.setup3 = host_wdata & `AFE_MASK_SETUP3;
        end
        if (wr_at(host_wr_en, host_addr, `AFE_ADDR_CYCRST))
        begin
            s_d.cyc_rst = 1'b1;
        end

        // Read data; strobes and gaps read zero
        if (host_rd_en)
        begin
            case (host_addr)
                `AFE_ADDR_SETUP1: s_d.rdata = s_q.setup1;
                `AFE_ADDR_SETUP2: s_d.rdata = s_q.setup2;
                `AFE_ADDR_SETUP3: s_d.rdata = s_q.setup3;
                default:          s_d.rdata = 8'h00;
            endcase
        end

        if (!s_q.setup1[`AFE_S1_SELECTIVE_POWERDOWN_ENABLE])
        begin
            s_d.chip_active = s_q.setup1[`AFE_S1_EN];
            s_d.block_en    = s_q.setup1[`AFE_S1_EN] ? 4'hF : 4'h0;
        end
        else
        begin
            s_d.chip_active = 1'b1;
            s_d.block_en    = ~block_disable_field;
        end

        s_d.cds = s_q.setup1[`AFE_S1_CDS];
        s_d.mono = s_q.setup1[`AFE_S1_MONO];
        s_d.chan = s_q.setup3[`AFE_S3_CHAN_LO +: 2];
        if (line_sequential_enable)
        begin
            s_d.mono = 1'b1;
            s_d.chan = 2'b00;
        end

        s_d.ofs       = s_q.setup1[`AFE_S1_OFS_LO +: 2];
        s_d.max_speed = s_q.setup1[`AFE_S1_MAXSPD];
        s_d.bus_fmt   = s_q.setup2[`AFE_S2_FMT_LO +: 2];
        s_d.invert    = s_q.setup2[`AFE_S2_INV];
        s_d.dac_oe    = !s_q.setup2[`AFE_S2_DACEXT];
        s_d.dac_span  = s_q.setup2[`AFE_S2_SPAN];
        s_d.lat_sel   = s_q.setup2[`AFE_S2_DEL_LO +: 2];
        s_d.lat_mclk  = to_mclk(s_q.setup2[`AFE_S2_DEL_LO +: 2], fast_line_mode);
        s_d.clamp_code   = s_q.setup3[`AFE_S3_CLAMP_LO +: 4];
        s_d.sample_shift = s_q.setup3[`AFE_S3_SHIFT_LO +: 2];

        if (wr_at(host_wr_en, host_addr, `AFE_ADDR_SOFTRST))
        begin
            // Every cell but soft_rst returns to default; soft_rst pulses to flush the data path
            s_d = RST_STATE;
            s_d.soft_rst = 1'b1;
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            s_q <= RST_STATE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // Outputs, all straight from flops
    // ****************************************
    assign host_rdata                 = s_q.rdata;
    assign chip_active                = s_q.chip_active;
    assign block_enable               = s_q.block_en;
    assign cds_enable                 = s_q.cds;
    assign mono_active                = s_q.mono;
    assign mono_channel               = s_q.chan;
    assign gain_stage_offset_polarity = s_q.ofs;
    assign max_speed_mode_flag        = s_q.max_speed;
    assign output_bus_format          = s_q.bus_fmt;
    assign output_invert              = s_q.invert;
    assign clamp_reference_dac_oe     = s_q.dac_oe;
    assign clamp_dac_span             = s_q.dac_span;
    assign output_latency_select      = s_q.lat_sel;
    assign latency_mclk               = s_q.lat_mclk;
    assign clamp_level_code           = s_q.clamp_code;
    assign reset_sample_shift         = s_q.sample_shift;
    assign soft_reset_pulse           = s_q.soft_rst;
    assign colour_cycle_reset         = s_q.cyc_rst;

    // Settings to the data path come from flops as well
    assign cfg_bus.invert   = s_q.invert;
    assign cfg_bus.lat_mclk = s_q.lat_mclk;
    assign cfg_bus.flush    = s_q.soft_rst;

    // ****************************************
    // Output data path
    // ****************************************
    afe_out_path #(
        .W     (DATA_W),
        .DEPTH (`AFE_MAX_LAT_MCLK)
    ) u_path (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .cfg      (cfg_bus.dp),
        .data_in  (adc_word),
        .data_out (data_out)
    );

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // A soft reset write forces the power state back on, so it is left out here
    property p_power_en;
        !s_q.setup1[`AFE_S1_SELECTIVE_POWERDOWN_ENABLE] && !wr_at(host_wr_en, host_addr, `AFE_ADDR_SOFTRST)
            |=> chip_active == $past(s_q.setup1[`AFE_S1_EN]);
    endproperty
    a_power_en: assert property (p_power_en)
        else $error("power state not following enable bit");

    property p_selective_powerdown_enable_ignores_en;
        s_q.setup1[`AFE_S1_SELECTIVE_POWERDOWN_ENABLE] && !wr_at(host_wr_en, host_addr, `AFE_ADDR_SOFTRST)
            |=> chip_active && block_enable == ~$past(block_disable_field);
    endproperty
    a_selective_powerdown_enable_ignores_en: assert property (p_selective_powerdown_enable_ignores_en)
        else $error("enable bit not ignored in selective mode");

    property p_cds;
        !wr_at(host_wr_en, host_addr, `AFE_ADDR_SOFTRST)
            |=> cds_enable == $past(s_q.setup1[`AFE_S1_CDS]);
    endproperty
    a_cds: assert property (p_cds)
        else $error("sampling method not following its bit");

    property p_line_forces_mono;
        line_sequential_enable && !wr_at(host_wr_en, host_addr, `AFE_ADDR_SOFTRST)
            |=> mono_active && mono_channel == 2'b00;
    endproperty
    a_line_forces_mono: assert property (p_line_forces_mono)
        else $error("line mode did not force mono channel zero");

    property p_soft_reset;
        wr_at(host_wr_en, host_addr, `AFE_ADDR_SOFTRST)
            |=> soft_reset_pulse && s_q.setup1 == `AFE_RST_SETUP1
                && s_q.setup2 == `AFE_RST_SETUP2 && s_q.setup3 == `AFE_RST_SETUP3
                ##1 data_out == '0;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("soft reset write did not restore defaults");

    property p_cycle_reset;
        wr_at(host_wr_en, host_addr, `AFE_ADDR_CYCRST) |=> colour_cycle_reset;
    endproperty
    a_cycle_reset: assert property (p_cycle_reset)
        else $error("cycle reset write gave no pulse");

    property p_latency_max;
        s_q.setup2[7:6] == 2'b11 && !fast_line_mode
            && !wr_at(host_wr_en, host_addr, `AFE_ADDR_SOFTRST)
            |=> latency_mclk == 4'h6;
    endproperty
    a_latency_max: assert property (p_latency_max)
        else $error("three converter periods not six master clocks");

    property p_dac_off;
        s_q.setup2[`AFE_S2_DACEXT] && !wr_at(host_wr_en, host_addr, `AFE_ADDR_SOFTRST)
            |=> !clamp_reference_dac_oe;
    endproperty
    a_dac_off: assert property (p_dac_off)
        else $error("clamp DAC still driving under override");

    property p_ofs;
        !wr_at(host_wr_en, host_addr, `AFE_ADDR_SOFTRST)
            |=> gain_stage_offset_polarity == $past(s_q.setup1[5:4]);
    endproperty
    a_ofs: assert property (p_ofs)
        else $error("offset polarity not following field");

    c_soft_reset: cover property (wr_at(host_wr_en, host_addr, `AFE_ADDR_SOFTRST));
    c_cycle_reset: cover property (colour_cycle_reset);
    c_line_mode: cover property (line_sequential_enable && mono_active);
    c_selective_powerdown_enable: cover property (s_q.setup1[`AFE_S1_SELECTIVE_POWERDOWN_ENABLE] && block_enable != 4'hF);
endmodule

// ==== testbench/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    // ********************************************
    // Stimulus and observed signals
    // ********************************************
    logic        core_clk;
    logic        rst_n;
    logic        host_wr_en;
    logic        host_rd_en;
    logic [5:0]  host_addr;
    logic [7:0]  host_wdata;
    logic        line_sequential_enable;
    logic        fast_line_mode;
    logic [3:0]  block_disable_field;
    logic [13:0] adc_word;
    logic [7:0]  host_rdata;
    logic        chip_active;
    logic [3:0]  block_enable;
    logic        cds_enable;
    logic        mono_active;
    logic [1:0]  mono_channel;
    logic [1:0]  gain_stage_offset_polarity;
    logic        max_speed_mode_flag;
    logic [1:0]  output_bus_format;
    logic        output_invert;
    logic        clamp_reference_dac_oe;
    logic        clamp_dac_span;
    logic [1:0]  output_latency_select;
    logic [3:0]  latency_mclk;
    logic [3:0]  clamp_level_code;
    logic [1:0]  reset_sample_shift;
    logic        soft_reset_pulse;
    logic        colour_cycle_reset;
    logic [13:0] data_out;
    logic [28:0] obs;          // All setting outputs in one word
    logic [7:0]  s1;           // Bench copy of the three setup registers
    logic [7:0]  s2;
    logic [7:0]  s3;
    logic [13:0] hist [0:63];  // Words fed to the data path, by cycle
    int          bad_count;
    int          checks;

    // One ordinary case: a write, the side inputs, the read-back it gives
    typedef struct {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic       lse;
        logic       fast;
        logic [3:0] dis;
        logic [7:0] rb;
    } afe_tb_row_s;

    // Masked bits (setup1 b7, setup2 b4) must read back as zero
    // max-speed flag only with FF and 45
    afe_tb_row_s rows [13] = '{
        '{6'h01, 8'hFF, 1'b0, 1'b0, 4'hA, 8'h7F}, '{6'h01, 8'h00, 1'b0, 1'b0, 4'h0, 8'h00},
        '{6'h01, 8'h45, 1'b0, 1'b0, 4'h0, 8'h45}, '{6'h01, 8'h2A, 1'b0, 1'b0, 4'h5, 8'h2A},
        '{6'h01, 8'h36, 1'b0, 1'b0, 4'h3, 8'h36}, '{6'h02, 8'hFF, 1'b0, 1'b0, 4'h0, 8'hEF},
        '{6'h02, 8'h41, 1'b0, 1'b1, 4'h0, 8'h41}, '{6'h02, 8'h8A, 1'b0, 1'b1, 4'h0, 8'h8A},
        '{6'h02, 8'hC7, 1'b0, 1'b0, 4'h0, 8'hC7}, '{6'h03, 8'h00, 1'b0, 1'b1, 4'h0, 8'h00},
        '{6'h03, 8'hA5, 1'b0, 1'b0, 4'h0, 8'hA5}, '{6'h03, 8'h3C, 1'b0, 1'b0, 4'h0, 8'h3C},
        '{6'h03, 8'h9A, 1'b1, 1'b0, 4'h0, 8'h9A}
    };

    assign obs = {chip_active, block_enable, cds_enable, mono_active, mono_channel,
                  gain_stage_offset_polarity, max_speed_mode_flag, output_bus_format,
                  output_invert, clamp_reference_dac_oe, clamp_dac_span,
                  output_latency_select, latency_mclk, clamp_level_code, reset_sample_shift};

    afe_regs afe_regs_inst (
        .core_clk(core_clk), .rst_n(rst_n), .host_wr_en(host_wr_en),
        .host_rd_en(host_rd_en), .host_addr(host_addr), .host_wdata(host_wdata),
        .line_sequential_enable(line_sequential_enable), .fast_line_mode(fast_line_mode),
        .block_disable_field(block_disable_field), .adc_word(adc_word),
        .host_rdata(host_rdata), .chip_active(chip_active), .block_enable(block_enable),
        .cds_enable(cds_enable), .mono_active(mono_active), .mono_channel(mono_channel),
        .gain_stage_offset_polarity(gain_stage_offset_polarity),
        .max_speed_mode_flag(max_speed_mode_flag), .output_bus_format(output_bus_format),
        .output_invert(output_invert), .clamp_reference_dac_oe(clamp_reference_dac_oe),
        .clamp_dac_span(clamp_dac_span), .output_latency_select(output_latency_select),
        .latency_mclk(latency_mclk), .clamp_level_code(clamp_level_code),
        .reset_sample_shift(reset_sample_shift), .soft_reset_pulse(soft_reset_pulse),
        .colour_cycle_reset(colour_cycle_reset), .data_out(data_out)
    );

    // ********************************************
    // Clock, 25 ns period
    // ********************************************
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // ********************************************
    // Helpers
    // ********************************************
    // Expected setting outputs, worked out from the bench copy of the registers
    function automatic logic [28:0] exp_obs();
        logic       sel;
        logic [3:0] mult;
        sel  = s1[3];
        mult = fast_line_mode ? 4'h3 : 4'h2;
        return {sel ? 1'b1 : s1[0], sel ? ~block_disable_field : {4{s1[0]}}, s1[1],
                line_sequential_enable | s1[2], line_sequential_enable ? 2'b00 : s3[7:6],
                s1[5:4], s1[6], s2[1:0], s2[2], ~s2[3], s2[5], s2[7:6],
                4'({2'b00, s2[7:6]} * mult), s3[3:0], s3[5:4]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Host write; strobe stands one cycle, entered between edges
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge core_clk);
        host_wr_en = 1'b1;
        host_addr  = a;
        host_wdata = d;
        @(negedge core_clk);
        host_wr_en = 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        @(negedge core_clk);
        host_rd_en = 1'b1;
        host_addr  = a;
        @(negedge core_clk);
        host_rd_en = 1'b0;
        chk(32'(host_rdata), 32'(exp));
    endtask

    // Derived outputs lag the registers by one edge, so allow margin
    task automatic check_settings();
        repeat (3) @(negedge core_clk);
        chk(32'(obs), 32'(exp_obs()));
    endtask

    task automatic check_defaults();
        s1 = 8'h03;
        s2 = 8'h20;
        s3 = 8'h1F;
        line_sequential_enable = 1'b0;
        check_settings();
        rd(6'h01, 8'h03);
        rd(6'h02, 8'h20);
        rd(6'h03, 8'h1F);
    endtask

    // Soft reset: any data value, pulse for one cycle, path flushed
    task automatic soft_reset(input logic [7:0] d);
        adc_word = 14'h0000;
        wr(6'h04, d);
        chk(32'(soft_reset_pulse), 32'h0000_0001);
        @(negedge core_clk);
        chk(32'({soft_reset_pulse, data_out}), 32'h0000_0000);
        check_defaults();
    endtask

    task automatic print_verdict();
        $display("checks %0d, bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ********************************************
    // Watchdog, well beyond the few hundred cycles the run needs
    // ********************************************
    initial
    begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        $display("watchdog expired at %0t", $time);
        print_verdict();
    end

    // ********************************************
    // Main sequence
    // ********************************************
    initial
    begin
        bad_count = 0;
        checks = 0;
        rst_n = 1'b0;
        host_wr_en = 1'b0;
        host_rd_en = 1'b0;
        host_addr = 6'h00;
        host_wdata = 8'h00;
        line_sequential_enable = 1'b0;
        fast_line_mode = 1'b0;
        block_disable_field = 4'h0;
        adc_word = 14'h0000;
        repeat (16) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        check_defaults();
        soft_reset(8'h00);

        // Ordinary cases from the table
        foreach (rows[i])
        begin
            @(negedge core_clk);
            line_sequential_enable = rows[i].lse;
            fast_line_mode = rows[i].fast;
            block_disable_field = rows[i].dis;
            wr(rows[i].addr, rows[i].wdata);
            case (rows[i].addr)
                6'h01: s1 = rows[i].rb;
                6'h02: s2 = rows[i].rb;
                default: s3 = rows[i].rb;
            endcase
            check_settings();
            rd(rows[i].addr, rows[i].rb);
        end

        // Unmapped and write-only places read zero and change nothing
        wr(6'h06, 8'hFF);
        rd(6'h06, 8'h00);
        rd(6'h04, 8'h00);
        rd(6'h05, 8'h00);
        check_settings();

        // Back-to-back writes, then a read in the same cycle as a write
        @(negedge core_clk);
        host_wr_en = 1'b1;
        host_addr = 6'h01;
        host_wdata = 8'h07;
        @(negedge core_clk);
        host_addr = 6'h02;
        host_wdata = 8'h04;
        @(negedge core_clk);
        host_addr = 6'h03;
        host_wdata = 8'h66;
        host_rd_en = 1'b1;
        @(negedge core_clk);
        host_wr_en = 1'b0;
        host_rd_en = 1'b0;
        chk(32'(host_rdata), 32'(s3));
        s1 = 8'h07;
        s2 = 8'h04;
        s3 = 8'h66;
        line_sequential_enable = 1'b0;
        check_settings();
        rd(6'h03, 8'h66);

        // Cycle reset in line mode: one-cycle pulse, settings untouched
        line_sequential_enable = 1'b1;
        wr(6'h05, 8'hC3);
        chk(32'(colour_cycle_reset), 32'h0000_0001);
        @(negedge core_clk);
        chk(32'(colour_cycle_reset), 32'h0000_0000);
        check_settings();

        // Data path: latency 0, 2 inverted, 9 in fast mode
        for (int c = 0; c < 3; c++)
        begin
            fast_line_mode = (c == 2);
            wr(6'h02, c == 0 ? 8'h20 : (c == 1 ? 8'h64 : 8'hE0));
            repeat (3) @(negedge core_clk);
            for (int j = 0; j < 40; j++)
            begin
                if (j >= 12)
                    chk(32'(data_out), 32'(14'((c == 1) ? ~hist[j - 3] :
                                           hist[j - 1 - (c == 2 ? 9 : 0)])));
                hist[j] = 14'(j * 291 + 85);
                adc_word = hist[j];
                @(negedge core_clk);
            end
        end

        // Soft reset in mid-run with a full pipe and odd data
        wr(6'h01, 8'h00);
        soft_reset(8'h5A);

        // Hard reset in mid-run
        wr(6'h03, 8'h00);
        rst_n = 1'b0;
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
        check_defaults();
        print_verdict();
    end
endmodule
